// ==== inc/udrt_pkg.sv ====
// Package for the up/down reload timer: register offsets, control bit layout, reset values.
// Assumes an 8-bit register port with byte offsets in the special function space.
package udrt_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFF_CONTROL = 8'hC8;
	localparam logic [7:0] OFF_MODE = 8'hC9;
	localparam logic [7:0] OFF_RELOAD_LOW = 8'hCA;
	localparam logic [7:0] OFF_RELOAD_HIGH = 8'hCB;
	localparam logic [7:0] OFF_COUNT_LOW = 8'hCC;
	localparam logic [7:0] OFF_COUNT_HIGH = 8'hCD;

	// ==========================================================
	// Control register bit positions; BIT_DOWN_EN is in the mode register
	localparam int BIT_OVERFLOW = 7;
	localparam int BIT_EXT_EVENT = 6;
	localparam int BIT_RX_BAUD = 5;
	localparam int BIT_TX_BAUD = 4;
	localparam int BIT_PIN_TRIG = 3;
	localparam int BIT_RUN = 2;
	localparam int BIT_SOURCE = 1;
	localparam int BIT_CAPTURE = 0;
	localparam int BIT_DOWN_EN = 0;

	// ==========================================================
	// Reset values and counts
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_TOP = 16'hFFFF;
	localparam int PRESCALE_DIV = 12;

	typedef enum logic [1:0] {
		UDRT_MODE_CAPTURE,
		UDRT_MODE_RELOAD,
		UDRT_MODE_BAUD
	} udrt_mode_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} udrt_req_type;

	typedef struct packed {
		logic count_pin;
		logic dir_trig_pin;
	} udrt_pins_type;

endpackage : udrt_pkg

// ==== rtl/udrt_timer.sv ====
// Sixteen-bit up/down auto-reload timer with capture and baud-rate overflow output.
// Assumes synchronous pins, 40 MHz core_clk standing in for the oscillator.
`timescale 1ns/100ps

module udrt_timer
	import udrt_pkg::*;
#(
	parameter int DIV = PRESCALE_DIV
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire udrt_pkg::udrt_req_type req,
	input wire udrt_pkg::udrt_pins_type pins,
	output logic [7:0] rdata,
	output logic irq,
	output logic baud_tick,
	output logic [15:0] count_out
);
	import udrt_pkg::*;

	// ==========================================================
	// State
	logic [7:0] control_q;
	logic down_en_q;
	logic [15:0] count_q;
	logic [15:0] reload_q;
	logic [$clog2(DIV)-1:0] pre_q;
	logic count_pin_q;
	logic dir_pin_q;
	logic [7:0] rdata_q;
	logic irq_q;
	logic baud_tick_q;
	logic [15:0] count_out_q;

	logic rx_baud, tx_baud, baud_use, run, tick, pin_fall, trig_fall;
	logic up, wrap_up, wrap_down, wrap, up_down_mode;
	udrt_mode_type mode;

	assign rx_baud = control_q[BIT_RX_BAUD];
	assign tx_baud = control_q[BIT_TX_BAUD];
	assign baud_use = rx_baud | tx_baud;
	assign run = control_q[BIT_RUN];
	assign pin_fall = count_pin_q & ~pins.count_pin;
	assign trig_fall = dir_pin_q & ~pins.dir_trig_pin;

	// Mode decode; baud bits override capture select
	always_comb begin
		if (baud_use) begin
			mode = UDRT_MODE_BAUD;
		end else if (control_q[BIT_CAPTURE]) begin
			mode = UDRT_MODE_CAPTURE;
		end else begin
			mode = UDRT_MODE_RELOAD;
		end
	end

	// Selected count input, gated by run control
	assign tick = run & (control_q[BIT_SOURCE] ? pin_fall : (pre_q == ($clog2(DIV))'(DIV - 1)));

	assign up_down_mode = (mode == UDRT_MODE_RELOAD) & down_en_q;
	assign up = ~up_down_mode | pins.dir_trig_pin;
	assign wrap_up = tick & up & (count_q == COUNT_TOP);
	assign wrap_down = tick & ~up & (count_q == reload_q);
	assign wrap = wrap_up | wrap_down;

	// ==========================================================
	// Prescaler; free running so the timer rate stays exact
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pre_q <= '0;
		end else if (clk_en) begin
			if (pre_q == ($clog2(DIV))'(DIV - 1)) begin
				pre_q <= '0;
			end else begin
				pre_q <= pre_q + 1'b1;
			end
		end
	end

	// Pin edge detection
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			count_pin_q <= 1'b1;
			dir_pin_q <= 1'b1;
		end else if (clk_en) begin
			count_pin_q <= pins.count_pin;
			dir_pin_q <= pins.dir_trig_pin;
		end
	end

	// ==========================================================
	// Counter; software write wins over counting
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			count_q <= COUNT_RESET;
		end else if (clk_en) begin
			if (req.wr && req.addr == OFF_COUNT_LOW) begin
				count_q[7:0] <= req.wdata;
			end else if (req.wr && req.addr == OFF_COUNT_HIGH) begin
				count_q[15:8] <= req.wdata;
			end else if (wrap_up && mode != UDRT_MODE_CAPTURE) begin
				count_q <= reload_q;
			end else if (wrap_down) begin
				count_q <= COUNT_TOP;
			end else if (trig_fall && control_q[BIT_PIN_TRIG] && !baud_use
				&& mode == UDRT_MODE_RELOAD && !down_en_q) begin
				count_q <= reload_q;
			end else if (tick) begin
				count_q <= up ? count_q + 16'h0001 : count_q - 16'h0001;
			end
		end
	end

	// Reload pair; capture copies the live count
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reload_q <= COUNT_RESET;
		end else if (clk_en) begin
			if (trig_fall && control_q[BIT_PIN_TRIG] && mode == UDRT_MODE_CAPTURE) begin
				reload_q <= count_q;
			end else if (req.wr && req.addr == OFF_RELOAD_LOW) begin
				reload_q[7:0] <= req.wdata;
			end else if (req.wr && req.addr == OFF_RELOAD_HIGH) begin
				reload_q[15:8] <= req.wdata;
			end
		end
	end

	// ==========================================================
	// Control register; hardware set beats a same-cycle software clear
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			control_q <= CONTROL_RESET;
			down_en_q <= 1'b0;
		end else if (clk_en) begin
			if (req.wr && req.addr == OFF_CONTROL) begin
				control_q <= req.wdata;
			end
			if (req.wr && req.addr == OFF_MODE) begin
				down_en_q <= req.wdata[BIT_DOWN_EN];
			end
			if (wrap && !baud_use) begin
				control_q[BIT_OVERFLOW] <= 1'b1;
			end
			if (wrap && up_down_mode) begin
				control_q[BIT_EXT_EVENT] <= ~control_q[BIT_EXT_EVENT];
			end else if (trig_fall && control_q[BIT_PIN_TRIG] && !baud_use && !up_down_mode) begin
				control_q[BIT_EXT_EVENT] <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Read port and outputs
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else if (clk_en) begin
			rdata_q <= 8'h00;
			if (req.rd) begin
				unique case (req.addr)
					OFF_CONTROL: rdata_q <= control_q;
					OFF_MODE: rdata_q <= {7'h00, down_en_q};
					OFF_RELOAD_LOW: rdata_q <= reload_q[7:0];
					OFF_RELOAD_HIGH: rdata_q <= reload_q[15:8];
					OFF_COUNT_LOW: rdata_q <= count_q[7:0];
					OFF_COUNT_HIGH: rdata_q <= count_q[15:8];
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
			baud_tick_q <= 1'b0;
			count_out_q <= COUNT_RESET;
		end else if (clk_en) begin
			// Up/down toggling of the external flag never interrupts
			irq_q <= control_q[BIT_OVERFLOW] | (control_q[BIT_EXT_EVENT] & ~up_down_mode);
			baud_tick_q <= wrap_up & baud_use;
			count_out_q <= count_q;
		end
	end

	assign rdata = rdata_q;
	assign irq = irq_q;
	assign baud_tick = baud_tick_q;
	assign count_out = count_out_q;

	// ==========================================================
	// Checks
	a_flag_on_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && wrap && !baud_use |=> control_q[BIT_OVERFLOW])
		else $error("overflow flag not set on wrap");
	a_no_flag_baud: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && baud_use && !control_q[BIT_OVERFLOW] && !(req.wr && req.addr == OFF_CONTROL)
		|=> !control_q[BIT_OVERFLOW])
		else $error("overflow flag set while baud in use");
	a_stop_holds: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && !run && !req.wr && !trig_fall |=> $stable(count_q))
		else $error("count moved while stopped");
	a_up_reload: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && wrap_up && mode != UDRT_MODE_CAPTURE && !req.wr |=> count_q == $past(reload_q))
		else $error("no reload after up overflow");
	a_down_top: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && wrap_down && !req.wr |=> count_q == COUNT_TOP)
		else $error("no FFFFh after underflow");
	a_ext_toggle: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && wrap && up_down_mode && !(req.wr && req.addr == OFF_CONTROL)
		|=> control_q[BIT_EXT_EVENT] != $past(control_q[BIT_EXT_EVENT]))
		else $error("external flag did not toggle");
	a_capture_copy: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && trig_fall && control_q[BIT_PIN_TRIG] && mode == UDRT_MODE_CAPTURE
		|=> reload_q == $past(count_q) && control_q[BIT_EXT_EVENT])
		else $error("capture did not copy count");
	a_count_step: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && tick && up && !wrap && !req.wr && !trig_fall |=> count_q == $past(count_q) + 16'h0001)
		else $error("count did not carry");
	a_prescale_rate: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && pre_q == '0 ##1 clk_en [*8] |-> pre_q == 4'h8)
		else $error("prescaler rate wrong");

	// ==========================================================
	// Checks: counting paths, reload pair and clock-enable freeze
	a_down_step: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && tick && !up && !wrap && !req.wr && !trig_fall |=> count_q == $past(count_q) - 16'h0001)
		else $error("count did not step down");

	a_up_only: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && !down_en_q && tick && !wrap && !req.wr && !trig_fall
		|=> count_q == $past(count_q) + 16'h0001)
		else $error("count not up with down disabled");

	a_counter_edge: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && run && control_q[BIT_SOURCE] && pin_fall && up && !wrap && !req.wr && !trig_fall
		|=> count_q == $past(count_q) + 16'h0001)
		else $error("pin fall not counted");

	a_source_pin: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && control_q[BIT_SOURCE] && !pin_fall && !req.wr && !trig_fall |=> $stable(count_q))
		else $error("count moved without pin edge");

	a_capture_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && wrap_up && mode == UDRT_MODE_CAPTURE && !req.wr |=> count_q == COUNT_RESET)
		else $error("capture mode wrap not to zero");

	a_baud_reload: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && wrap_up && baud_use && !req.wr |=> count_q == $past(reload_q))
		else $error("baud overflow did not reload");

	a_pin_reload: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && trig_fall && control_q[BIT_PIN_TRIG] && mode == UDRT_MODE_RELOAD
		&& !down_en_q && !req.wr && !wrap |=> count_q == $past(reload_q))
		else $error("pin trigger did not reload");

	a_pin_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && trig_fall && !control_q[BIT_PIN_TRIG] && !req.wr |=> $stable(reload_q))
		else $error("reload pair moved with pin disabled");

	a_freeze_all: assert property (@(posedge core_clk) disable iff (!resetn)
		!clk_en |=> $stable(count_q) && $stable(control_q) && $stable(reload_q))
		else $error("state moved while clock enable low");

	// ==========================================================
	// Checks: flags and interrupt
	a_flag_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && control_q[BIT_OVERFLOW] && !(req.wr && req.addr == OFF_CONTROL)
		|=> control_q[BIT_OVERFLOW])
		else $error("overflow flag cleared by hardware");

	a_ext_on_trig: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && trig_fall && control_q[BIT_PIN_TRIG] && !baud_use && !up_down_mode
		|=> control_q[BIT_EXT_EVENT])
		else $error("external flag not set by trigger");

	a_no_ext_baud: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && baud_use && !control_q[BIT_EXT_EVENT] && !(req.wr && req.addr == OFF_CONTROL)
		|=> !control_q[BIT_EXT_EVENT])
		else $error("external flag set while baud in use");

	a_irq_follow: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en |=> irq_q == ($past(control_q[BIT_OVERFLOW])
		| ($past(control_q[BIT_EXT_EVENT]) & ~$past(up_down_mode))))
		else $error("interrupt does not follow flags");

	a_no_irq_updown: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && up_down_mode && !control_q[BIT_OVERFLOW] |=> !irq_q)
		else $error("interrupt from up/down external flag");

	// ==========================================================
	// Checks: register port and outputs
	a_write_low: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && req.wr && req.addr == OFF_COUNT_LOW |=> count_q[7:0] == $past(req.wdata))
		else $error("count low write lost");

	a_write_high: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && req.wr && req.addr == OFF_COUNT_HIGH |=> count_q[15:8] == $past(req.wdata))
		else $error("count high write lost");

	a_mode_write: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && req.wr && req.addr == OFF_MODE |=> down_en_q == $past(req.wdata[BIT_DOWN_EN]))
		else $error("down enable write lost");

	a_read_low: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && req.rd && req.addr == OFF_COUNT_LOW |=> rdata_q == $past(count_q[7:0]))
		else $error("count low read wrong");

	a_read_high: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && req.rd && req.addr == OFF_COUNT_HIGH |=> rdata_q == $past(count_q[15:8]))
		else $error("count high read wrong");

	a_rdata_idle: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && !req.rd |=> rdata_q == 8'h00)
		else $error("read data not cleared");

	a_baud_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && wrap_up && baud_use |=> baud_tick_q)
		else $error("baud tick missing");

	a_no_baud_tick: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && !baud_use |=> !baud_tick_q)
		else $error("baud tick without baud use");

	a_count_mirror: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en |=> count_out_q == $past(count_q))
		else $error("count output does not mirror count");

endmodule : udrt_timer

// ==== bench/udrt_pin_model.sv ====
// Far-side model: the external count pin and the direction/trigger pin.
// Assumes the bench calls its tasks; both pins idle high and change after core_clk edges.
`timescale 1ns/100ps

module udrt_pin_model
	import udrt_pkg::*;
(
	input wire logic core_clk,
	output udrt_pkg::udrt_pins_type pins
);
	// ==========================================================
	// Pin drivers
	initial pins = 2'b11;

	// Each falling edge is held low two cycles so the sampler sees it
	task automatic pulse_count(input int n);
		repeat (n) begin
			@(posedge core_clk) pins.count_pin <= 1'b0;
			repeat (2) @(posedge core_clk);
			pins.count_pin <= 1'b1;
			repeat (2) @(posedge core_clk);
		end
	endtask : pulse_count

	// Level sets direction; a high-to-low step is also a trigger
	task automatic set_dir(input logic v);
		@(posedge core_clk) pins.dir_trig_pin <= v;
		repeat (3) @(posedge core_clk);
	endtask : set_dir
endmodule : udrt_pin_model

// ==== bench/udrt_timer_test.sv ====
// Self-checking bench for the up/down reload timer.
// Assumes the pin model drives the pins and the bench is the register master.
`timescale 1ns/100ps

module udrt_timer_test;
	import udrt_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic clk_en;
	udrt_req_type req;
	udrt_pins_type pins;
	logic [7:0] rdata;
	logic irq;
	logic baud_tick;
	logic [15:0] count_out;
	int n_errors = 0;
	int samples_checked = 0;
	int n_ticks = 0;

	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (baud_tick === 1'b1) n_ticks++;

	udrt_timer #(.DIV(PRESCALE_DIV)) u_udrt_timer (.core_clk(core_clk), .resetn(resetn),
		.clk_en(clk_en), .req(req), .pins(pins), .rdata(rdata), .irq(irq),
		.baud_tick(baud_tick), .count_out(count_out));
	udrt_pin_model u_udrt_pin_model (.core_clk(core_clk), .pins(pins));

	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk) req.wr <= 1'b0;
	endtask : wr

	task automatic reg_is(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge core_clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk) req.rd <= 1'b0;
		#1 check(what, {8'h00, rdata}, {8'h00, exp});
	endtask : reg_is

	task automatic load(input logic [15:0] cnt, input logic [15:0] rl, input logic [7:0] md);
		wr(OFF_CONTROL, 8'h00);
		wr(OFF_COUNT_LOW, cnt[7:0]);
		wr(OFF_COUNT_HIGH, cnt[15:8]);
		wr(OFF_RELOAD_LOW, rl[7:0]);
		wr(OFF_RELOAD_HIGH, rl[15:8]);
		wr(OFF_MODE, md);
	endtask : load

	task automatic settle_is(input logic [15:0] exp, input string what);
		repeat (3) @(posedge core_clk);
		#1 check(what, count_out, exp);
	endtask : settle_is

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		for (int i = 0; i < 8; i++) reg_is(8'hC8 + i[7:0], 8'h00, "reset reg");
		clk_en <= 1'b0;
		wr(OFF_COUNT_LOW, 8'h5A);
		clk_en <= 1'b1;
		reg_is(OFF_COUNT_LOW, 8'h00, "frozen write");
		$display("done reset");
	endtask : t_reset

	task automatic t_counter;
		load(16'h00FE, 16'h0000, 8'h00);
		wr(OFF_CONTROL, 8'h06);
		u_udrt_pin_model.pulse_count(3);
		settle_is(16'h0101, "carry");
		wr(OFF_CONTROL, 8'h02);
		u_udrt_pin_model.pulse_count(2);
		settle_is(16'h0101, "stopped");
		load(16'h0000, 16'h0000, 8'h00);
		wr(OFF_CONTROL, 8'h04);
		repeat (240) @(posedge core_clk);
		wr(OFF_CONTROL, 8'h00);
		repeat (3) @(posedge core_clk);
		#1 check("div value", {15'h0000, count_out inside {16'd20, 16'd21}}, 16'h0001);
		settle_is(count_out, "div stopped");
		$display("done counter");
	endtask : t_counter

	task automatic t_updown;
		u_udrt_pin_model.set_dir(1'b0);
		load(16'hFFFE, 16'h1234, 8'h00);
		wr(OFF_CONTROL, 8'h06);
		u_udrt_pin_model.pulse_count(2);
		settle_is(16'h1234, "up reload");
		reg_is(OFF_CONTROL, 8'h86, "ovf flag");
		check("ovf irq", {15'h0000, irq}, 16'h0001);
		wr(OFF_CONTROL, 8'h06);
		settle_is(16'h1234, "hold");
		check("irq cleared", {15'h0000, irq}, 16'h0000);
		load(16'h0012, 16'h0010, 8'h01);
		wr(OFF_CONTROL, 8'h0E);
		u_udrt_pin_model.pulse_count(3);
		settle_is(16'hFFFF, "underflow");
		reg_is(OFF_CONTROL, 8'hCE, "ext toggle");
		wr(OFF_CONTROL, 8'h4E);
		settle_is(16'hFFFF, "hold");
		check("no ext irq", {15'h0000, irq}, 16'h0000);
		u_udrt_pin_model.set_dir(1'b1);
		u_udrt_pin_model.pulse_count(1);
		settle_is(16'h0010, "updown up");
		reg_is(OFF_CONTROL, 8'h8E, "ext back");
		$display("done updown");
	endtask : t_updown

	task automatic t_capture;
		load(16'h0ABC, 16'h0000, 8'h00);
		wr(OFF_CONTROL, 8'h01);
		u_udrt_pin_model.set_dir(1'b0);
		u_udrt_pin_model.set_dir(1'b1);
		reg_is(OFF_RELOAD_LOW, 8'h00, "pin ignored");
		wr(OFF_CONTROL, 8'h09);
		u_udrt_pin_model.set_dir(1'b0);
		reg_is(OFF_RELOAD_LOW, 8'hBC, "cap low");
		reg_is(OFF_RELOAD_HIGH, 8'h0A, "cap high");
		reg_is(OFF_CONTROL, 8'h49, "cap flag");
		check("cap irq", {15'h0000, irq}, 16'h0001);
		u_udrt_pin_model.set_dir(1'b1);
		load(16'h0055, 16'h3000, 8'h00);
		wr(OFF_CONTROL, 8'h08);
		u_udrt_pin_model.set_dir(1'b0);
		settle_is(16'h3000, "pin reload");
		reg_is(OFF_CONTROL, 8'h48, "reload flag");
		u_udrt_pin_model.set_dir(1'b1);
		$display("done capture");
	endtask : t_capture

	task automatic t_baud;
		load(16'hFFFF, 16'hFF00, 8'h00);
		wr(OFF_CONTROL, 8'h1F);
		n_ticks = 0;
		u_udrt_pin_model.pulse_count(1);
		settle_is(16'hFF00, "forced reload");
		check("baud ticks", n_ticks[15:0], 16'h0001);
		u_udrt_pin_model.set_dir(1'b0);
		settle_is(16'hFF00, "baud pin");
		reg_is(OFF_CONTROL, 8'h1F, "no flags");
		u_udrt_pin_model.set_dir(1'b1);
		$display("done baud");
	endtask : t_baud

	// ==========================================================
	// Run control
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	initial begin
		clk_en <= 1'b1;
		req <= '0;
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		t_counter();
		t_updown();
		t_capture();
		t_baud();
		tally_and_finish();
	end

	// Whole run needs about 520 cycles; the 20000-cycle limit is ample margin
	initial begin
		#(25 * 20000);
		n_errors++;
		tally_and_finish();
	end
endmodule : udrt_timer_test
